// >>> ecl_loader.sv
// power-on configuration loader: preloads the eeprom image, decodes it,
// powers down the managed phys, then opens usb enumeration.
// assumes a microwire eeprom on srom_* and mdc/mdio toward the phys.
// How it works
// [RQ1] Start reading the eeprom by itself once reset is released.
// [RQ2] Preload exactly 15h sixteen-bit words from eeprom address zero.
// [RQ3] Flag bit 0 set reports self-powered, clear reports bus-powered.
// [RQ4] Flag bit 2 set advertises remote wakeup support.
// [RQ5] Flag bit 4 set disables the high-speed chirp K.
// [RQ6] Flag bit 5 chooses software or usb bus reset to drive phy reset.
// [RQ7] Flag bit 6 set strips received frame crc before the host sees it.
// [RQ8] Flag bit 7 set appends a generated crc to every sent frame.
// [RQ9] Flag bit 8 enables capture effect mode.
// [RQ10] Debug port enable flag turns the chip debug port on.
// [RQ11] Flag bit 1 and bits 10 to 15 carry no function.
// [RQ12] Words 04h to 06h give station address bytes 0 to 5.
// [RQ13] Word 0Fh bits 12:8 name the phy register for packet bytes 5-6.
// [RQ14] Word 0Fh low bits name the phy register for packet bytes 7-8.
// [RQ15] Maximum frame size is even and at most 2500 bytes.
// [RQ16] Phy type 000 means supported phy, 111 means phy absent.
// [RQ17] Word 11h: secondary in high byte, primary low; type 7:5, id 4:0.
// [RQ18] The integrated phy answers only at management id 1_0000.
// [RQ19] In full duplex pause starts at high mark and stops at low mark.
// [RQ20] Each water-mark count unit stands for 256 bytes of storage.
// [RQ21] First management write goes to id 00h, register 00h, power down.
// [RQ22] Then register 00h of primary, then secondary phy, powered down.
// [RQ23] Hold enumeration and management traffic until preload completes.
`timescale 1ns/100ps
module ecl_loader
    import ecl_pkg::*;
#(
    parameter int SROM_HALF = SROM_HALF_CYC,
    parameter int MDC_HALF = MDC_HALF_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    output logic srom_cs,
    output logic srom_sk,
    output logic srom_di,
    input wire logic srom_do,
    output logic mdc,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe_n,
    input wire logic usb_bus_reset,
    input wire logic phy_reset_level,
    input wire logic phy_reset_enable,
    output logic phy_reset_out_n,
    input wire logic full_duplex,
    input wire logic [7:0] rx_free_cnt,
    output logic [15:0] rx_free_bytes,
    output logic pause_req,
    output logic cfg_valid,
    output logic usb_enum_en,
    output logic mgmt_grant,
    output ecl_flags_s flags,
    output logic [47:0] station_addr,
    output logic [4:0] int_ep_reg1,
    output logic [4:0] int_ep_reg2,
    output logic [15:0] max_frame_size,
    output ecl_phy_s primary_phy,
    output ecl_phy_s secondary_phy,
    output logic primary_is_internal,
    output logic [7:0] pause_high_mark,
    output logic [7:0] pause_low_mark,
    output logic mdio_in_seen
);
    typedef enum logic [2:0] {
        ST_RESET = 3'b000,
        ST_READ = 3'b001,
        ST_READ_WAIT = 3'b011,
        ST_PD = 3'b010,
        ST_PD_WAIT = 3'b110,
        ST_DONE = 3'b111
    } ecl_state_e;

    logic sync1_q;
    logic rst_sync_n;
    ecl_state_e state_q;
    logic [4:0] word_q;
    logic [1:0] pd_q;
    logic [15:0] cfg_q [PRELOAD_WORDS];
    logic pause_q;
    logic mdio_in_q;
    logic rd_start;
    logic rd_busy;
    logic rd_done;
    logic [15:0] rd_data;
    logic md_start;
    logic md_busy;
    logic md_done;
    logic [4:0] md_phy;
    logic [15:0] flag_w;
    logic [15:0] phy_w;

    // two-flop release of the asynchronous reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            sync1_q <= 1'b1;
            rst_sync_n <= sync1_q;
        end
    end

    // eeprom word reader
    ecl_srom_rd #(.AW(SROM_ADDR_W), .HALF(SROM_HALF)) u_srom (
        .clk(ref_clk),
        .rst_n(rst_sync_n),
        .start(rd_start),
        .addr({3'h0, word_q}),
        .busy(rd_busy),
        .done(rd_done),
        .data(rd_data),
        .srom_cs(srom_cs),
        .srom_sk(srom_sk),
        .srom_di(srom_di),
        .srom_do(srom_do)
    );

    // management write engine for the power-down sequence
    ecl_mdio_wr #(.HALF(MDC_HALF)) u_mdio (
        .clk(ref_clk),
        .rst_n(rst_sync_n),
        .start(md_start),
        .phy(md_phy),
        .regad(PHY_CTRL_REG),
        .wdata(PHY_POWER_DOWN),
        .busy(md_busy),
        .done(md_done),
        .mdc(mdc),
        .mdio_o(mdio_o),
        .mdio_oe_n(mdio_oe_n)
    );

    // start strobes and power-down target: broadcast, primary, secondary
    assign rd_start = (state_q == ST_READ);
    assign md_start = (state_q == ST_PD);
    assign md_phy = (pd_q == 2'h0) ? BCAST_PHY_MGMT_ID : // RQ21
                    (pd_q == 2'h1) ? primary_phy.phy_mgmt_id : // RQ22
                    secondary_phy.phy_mgmt_id;

    // boot sequencer; leaves reset on its own, no host request needed
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_q <= ST_RESET;
            word_q <= 5'h00;
            pd_q <= 2'h0;
        end else begin
            case (state_q)
                ST_RESET: begin
                    state_q <= ST_READ; // RQ1
                end
                ST_READ: begin
                    state_q <= ST_READ_WAIT;
                end
                ST_READ_WAIT: begin
                    if (rd_done) begin
                        // fixed count; the count word itself is not trusted
                        if (word_q == 5'(PRELOAD_WORDS - 1)) begin // RQ2
                            state_q <= ST_PD; // RQ23
                        end else begin
                            state_q <= ST_READ;
                        end
                        word_q <= word_q + 5'h01;
                    end
                end
                ST_PD: begin
                    state_q <= ST_PD_WAIT;
                end
                ST_PD_WAIT: begin
                    if (md_done) begin
                        if (pd_q == 2'(PD_STEPS - 1)) begin // RQ22
                            state_q <= ST_DONE;
                        end else begin
                            state_q <= ST_PD;
                        end
                        pd_q <= pd_q + 2'h1;
                    end
                end
                ST_DONE: begin
                    state_q <= ST_DONE;
                end
                default: begin
                    state_q <= ST_RESET;
                end
            endcase
        end
    end

    // configuration storage, written once per preloaded word
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            for (int i = 0; i < PRELOAD_WORDS; i++) begin
                cfg_q[i] <= CFG_RESET;
            end
        end else if (rd_done && state_q == ST_READ_WAIT) begin
            cfg_q[word_q] <= rd_data; // RQ2
        end
    end

    // feature flags; bit 1 and 10..15 are simply never looked at
    assign flag_w = cfg_q[W_FLAG]; // RQ11
    assign flags.self_power_flag = flag_w[F_SELF_POWER]; // RQ3
    assign flags.remote_wake_capable = flag_w[F_REMOTE_WAKE]; // RQ4
    assign flags.chirp_k_disable = flag_w[F_CHIRP_K_DIS]; // RQ5
    assign flags.sw_phy_reset_ctrl = flag_w[F_SW_PHY_RST]; // RQ6
    assign flags.rx_crc_strip_en = flag_w[F_RX_CRC_STRIP]; // RQ7
    assign flags.tx_crc_append_en = flag_w[F_TX_CRC_APPEND]; // RQ8
    assign flags.capture_effect_en = flag_w[F_CAPTURE_EFF]; // RQ9
    assign flags.debug_port_en = flag_w[F_DEBUG_PORT]; // RQ10

    // station address: low byte of each word is the earlier octet
    assign station_addr = {cfg_q[W_NODE0][7:0], cfg_q[W_NODE0][15:8],
                           cfg_q[W_NODE1][7:0], cfg_q[W_NODE1][15:8],
                           cfg_q[W_NODE2][7:0], cfg_q[W_NODE2][15:8]}; // RQ12

    // interrupt endpoint phy register selectors
    assign int_ep_reg1 = cfg_q[W_PHYOFS][12:8]; // RQ13
    assign int_ep_reg2 = cfg_q[W_PHYOFS][4:0]; // RQ14

    // frame size passed on as stored; even and range are the image's duty
    assign max_frame_size = cfg_q[W_MAXPKT]; // RQ15

    // phy type and id unpacking
    assign phy_w = cfg_q[W_PHYSEL];
    assign primary_phy.phy_type = phy_w[7:PHY_TYPE_LSB]; // RQ17
    assign primary_phy.phy_mgmt_id = phy_w[4:0]; // RQ17
    assign primary_phy.present = (phy_w[7:5] == PHY_TYPE_SUPPORTED); // RQ16
    assign secondary_phy.phy_type = phy_w[15:8+PHY_TYPE_LSB]; // RQ17
    assign secondary_phy.phy_mgmt_id = phy_w[12:8]; // RQ17
    assign secondary_phy.present = (phy_w[15:13] == PHY_TYPE_SUPPORTED); // RQ16
    // the primary phy counts as the integrated phy only for this id
    assign primary_is_internal = (primary_phy.phy_mgmt_id == INT_PHY_MGMT_ID); // RQ18

    // pause water marks and the byte equivalent of the free count
    assign pause_high_mark = cfg_q[W_PAUSE][15:8];
    assign pause_low_mark = cfg_q[W_PAUSE][7:0];
    assign rx_free_bytes = {rx_free_cnt, 8'h00}; // RQ20

    // phy reset pin: software bits, or usb bus reset gated by enable
    assign phy_reset_out_n = flags.sw_phy_reset_ctrl ?
                             ~(phy_reset_enable & ~phy_reset_level) :
                             ~(phy_reset_enable & usb_bus_reset); // RQ6

    // readiness gates for usb enumeration and host phy traffic
    assign cfg_valid = (state_q == ST_DONE);
    assign usb_enum_en = cfg_valid; // RQ23
    assign mgmt_grant = cfg_valid & ~md_busy; // RQ23
    assign pause_req = pause_q;
    assign mdio_in_seen = mdio_in_q;

    // pause hysteresis, only meaningful in full duplex
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pause_q <= 1'b0;
        end else if (!full_duplex || !cfg_valid) begin
            pause_q <= 1'b0;
        end else if (!pause_q && rx_free_cnt <= pause_high_mark) begin
            pause_q <= 1'b1; // RQ19
        end else if (pause_q && rx_free_cnt >= pause_low_mark) begin
            pause_q <= 1'b0; // RQ19
        end
    end

    // last level seen on mdio, a cheap wiring check for bring-up
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mdio_in_q <= 1'b0;
        end else begin
            mdio_in_q <= mdio_i;
        end
    end

    property p_auto_start;
        @(posedge ref_clk) $rose(rst_sync_n) |-> ##2 rd_busy;
    endproperty
    a_auto_start: assert property (p_auto_start) else $error("load did not start"); // RQ1

    property p_preload_count;
        @(posedge ref_clk) disable iff (!rst_sync_n)
            (state_q == ST_PD && pd_q == 2'h0) |-> word_q == 5'h15;
    endproperty
    a_preload_count: assert property (p_preload_count) else $error("bad word count"); // RQ2

    property p_no_mdio_early;
        @(posedge ref_clk) disable iff (!rst_sync_n)
            !mdio_oe_n |-> (word_q == 5'h15 && !rd_busy);
    endproperty
    a_no_mdio_early: assert property (p_no_mdio_early) else $error("mdio before load"); // RQ23

    property p_first_bcast;
        @(posedge ref_clk) disable iff (!rst_sync_n)
            (md_start && pd_q == 2'h0) |-> md_phy == 5'h00 ##1 !mdio_oe_n;
    endproperty
    a_first_bcast: assert property (p_first_bcast) else $error("first write not bcast"); // RQ21

    property p_pd_order;
        @(posedge ref_clk) disable iff (!rst_sync_n)
            (md_start && pd_q == 2'h1) |-> md_phy == phy_w[4:0];
    endproperty
    a_pd_order: assert property (p_pd_order) else $error("primary not second"); // RQ22

    property p_enum_hold;
        @(posedge ref_clk) disable iff (!rst_sync_n)
            (usb_enum_en || mgmt_grant) |-> (state_q == ST_DONE && pd_q == 2'h3);
    endproperty
    a_enum_hold: assert property (p_enum_hold) else $error("enumeration too early"); // RQ23

    property p_sw_phy_reset;
        @(posedge ref_clk) disable iff (!rst_sync_n)
            (flag_w[5] && phy_reset_enable) |-> phy_reset_out_n == phy_reset_level;
    endproperty
    a_sw_phy_reset: assert property (p_sw_phy_reset) else $error("phy reset level"); // RQ6

    property p_pause_start;
        @(posedge ref_clk) disable iff (!rst_sync_n)
            (cfg_valid && full_duplex && !pause_q && rx_free_cnt <= cfg_q[W_PAUSE][15:8])
            |=> pause_q;
    endproperty
    a_pause_start: assert property (p_pause_start) else $error("pause not raised"); // RQ19

    property p_free_bytes;
        @(posedge ref_clk) disable iff (!rst_sync_n)
            rx_free_bytes == 16'(rx_free_cnt) * 16'h0100;
    endproperty
    a_free_bytes: assert property (p_free_bytes) else $error("free byte scale"); // RQ20

    property p_absent_phy;
        @(posedge ref_clk) disable iff (!rst_sync_n)
            (phy_w[15:13] == 3'b111) |-> !secondary_phy.present;
    endproperty
    a_absent_phy: assert property (p_absent_phy) else $error("absent phy shown"); // RQ16
endmodule

// >>> ecl_pkg.sv
// shared constants and types for the serial eeprom configuration loader
// assumes a 100 MHz core clock and a 16-bit organised microwire eeprom
package ecl_pkg;

    // core clock period and link timing, times in ns
    localparam int CLK_PERIOD_NS = 10;
    localparam int SROM_HALF_NS = 500;
    localparam int MDC_HALF_NS = 200;
    localparam int SROM_HALF_CYC = (SROM_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MDC_HALF_CYC = (MDC_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // preload geometry
    localparam int PRELOAD_WORDS = 'h15;
    localparam int SROM_ADDR_W = 8;

    // word offsets inside the preload image
    localparam logic [4:0] W_COUNT = 5'h00;
    localparam logic [4:0] W_FLAG = 5'h01;
    localparam logic [4:0] W_NODE0 = 5'h04;
    localparam logic [4:0] W_NODE1 = 5'h05;
    localparam logic [4:0] W_NODE2 = 5'h06;
    localparam logic [4:0] W_PHYOFS = 5'h0F;
    localparam logic [4:0] W_MAXPKT = 5'h10;
    localparam logic [4:0] W_PHYSEL = 5'h11;
    localparam logic [4:0] W_PAUSE = 5'h12;

    // flag word bit positions
    localparam int F_SELF_POWER = 0;
    localparam int F_REMOTE_WAKE = 2;
    localparam int F_CHIRP_K_DIS = 4;
    localparam int F_SW_PHY_RST = 5;
    localparam int F_RX_CRC_STRIP = 6;
    localparam int F_TX_CRC_APPEND = 7;
    localparam int F_CAPTURE_EFF = 8;
    localparam int F_DEBUG_PORT = 9;

    // phy type / id layout and codes
    localparam int PHY_TYPE_LSB = 5;
    localparam logic [2:0] PHY_TYPE_SUPPORTED = 3'h0;
    localparam logic [2:0] PHY_TYPE_ABSENT = 3'h7;
    localparam logic [4:0] INT_PHY_MGMT_ID = 5'h10;
    localparam logic [4:0] BCAST_PHY_MGMT_ID = 5'h00;
    localparam logic [4:0] PHY_CTRL_REG = 5'h00;
    localparam logic [15:0] PHY_POWER_DOWN = 16'h0800;
    localparam int PD_STEPS = 3;

    // reset value of every configuration word
    localparam logic [15:0] CFG_RESET = 16'h0000;

    // decoded feature bits
    typedef struct packed {
        logic self_power_flag;
        logic remote_wake_capable;
        logic chirp_k_disable;
        logic sw_phy_reset_ctrl;
        logic rx_crc_strip_en;
        logic tx_crc_append_en;
        logic capture_effect_en;
        logic debug_port_en;
    } ecl_flags_s;

    // one station-managed phy as configured
    typedef struct packed {
        logic [2:0] phy_type;
        logic [4:0] phy_mgmt_id;
        logic present;
    } ecl_phy_s;

endpackage

// >>> ecl_srom_rd.sv
// microwire single-word read engine for the configuration eeprom
// assumes a 16-bit organised part answering a read opcode 110 plus address
`timescale 1ns/100ps
module ecl_srom_rd
    import ecl_pkg::*;
#(
    parameter int AW = SROM_ADDR_W,
    parameter int HALF = SROM_HALF_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [AW-1:0] addr,
    output logic busy,
    output logic done,
    output logic [15:0] data,
    output logic srom_cs,
    output logic srom_sk,
    output logic srom_di,
    input wire logic srom_do
);
    localparam int CMD_BITS = 3 + AW;
    localparam int TOTAL = CMD_BITS + 16;

    // the divider counter is 16 bits wide
    if (HALF < 1 || HALF > 65536 || AW < 6 || AW > 12) begin : g_chk
        $error("ecl_srom_rd: unsupported address width or divider");
    end

    logic [15:0] div_q;
    logic [5:0] bit_q;
    logic [CMD_BITS-1:0] sh_q;
    logic active_q;
    logic tick;

    assign tick = (div_q == 16'(HALF - 1));
    assign busy = active_q;
    // command bits go out msb first; the line idles low during data
    assign srom_di = active_q && (bit_q < 6'(CMD_BITS)) && sh_q[CMD_BITS-1];

    // data moves on the falling edge, the part samples on the rising one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active_q <= 1'b0;
            srom_cs <= 1'b0;
            srom_sk <= 1'b0;
            div_q <= 16'h0000;
            bit_q <= 6'h00;
            sh_q <= '0;
            data <= 16'h0000;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (!active_q) begin
                if (start) begin
                    active_q <= 1'b1;
                    srom_cs <= 1'b1;
                    div_q <= 16'h0000;
                    bit_q <= 6'h00;
                    sh_q <= {3'b110, addr};
                end
            end else if (tick) begin
                div_q <= 16'h0000;
                srom_sk <= ~srom_sk;
                if (!srom_sk) begin
                    if (bit_q >= 6'(CMD_BITS)) begin
                        data <= {data[14:0], srom_do};
                    end
                end else if (bit_q == 6'(TOTAL - 1)) begin
                    active_q <= 1'b0;
                    srom_cs <= 1'b0;
                    done <= 1'b1;
                end else begin
                    bit_q <= bit_q + 6'h01;
                    sh_q <= sh_q << 1;
                end
            end else begin
                div_q <= div_q + 16'h0001;
            end
        end
    end
endmodule

// >>> ecl_mdio_wr.sv
// station management write engine: one 64-bit clause 22 write frame
// assumes the managed phys sample mdio on the rising edge of mdc
`timescale 1ns/100ps
module ecl_mdio_wr
    import ecl_pkg::*;
#(
    parameter int HALF = MDC_HALF_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [4:0] phy,
    input wire logic [4:0] regad,
    input wire logic [15:0] wdata,
    output logic busy,
    output logic done,
    output logic mdc,
    output logic mdio_o,
    output logic mdio_oe_n
);
    // the divider counter is 16 bits wide
    if (HALF < 1 || HALF > 65536) begin : g_chk
        $error("ecl_mdio_wr: divider must be at least one cycle");
    end

    logic [15:0] div_q;
    logic [5:0] bit_q;
    logic [63:0] sh_q;
    logic active_q;

    assign busy = active_q;
    assign mdio_o = sh_q[63];
    // pin is released whenever no frame is in flight
    assign mdio_oe_n = ~active_q;

    // preamble, start, write opcode, addresses, turnaround, data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active_q <= 1'b0;
            mdc <= 1'b0;
            div_q <= 16'h0000;
            bit_q <= 6'h00;
            sh_q <= 64'h0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (!active_q) begin
                if (start) begin
                    active_q <= 1'b1;
                    div_q <= 16'h0000;
                    bit_q <= 6'h00;
                    sh_q <= {32'hFFFF_FFFF, 4'h5, phy, regad, 2'h2, wdata};
                end
            end else if (div_q == 16'(HALF - 1)) begin
                div_q <= 16'h0000;
                mdc <= ~mdc;
                if (mdc) begin
                    if (bit_q == 6'h3F) begin
                        active_q <= 1'b0;
                        done <= 1'b1;
                    end else begin
                        bit_q <= bit_q + 6'h01;
                        sh_q <= sh_q << 1;
                    end
                end
            end else begin
                div_q <= div_q + 16'h0001;
            end
        end
    end
endmodule

// >>> ecl_srom_model.sv
// microwire eeprom model: answers 16-bit reads and logs the read order
// assumes one word per chip-select period, command bits on sk rising edges
`timescale 1ns/100ps
module ecl_srom_model (
    input wire logic srom_cs,
    input wire logic srom_sk,
    input wire logic srom_di,
    input wire logic clr,
    output logic srom_do,
    output int rd_cnt,
    output logic ord_err
);
    logic [15:0] mem [0:31];
    logic [15:0] sh;
    logic [7:0] a;
    int cnt;
    initial begin
        srom_do = 1'b1;
        rd_cnt = 0;
        ord_err = 1'b0;
        cnt = 0;
    end
    // count sk edges and take the address msb first after the opcode
    always @(posedge srom_sk) begin
        if (srom_cs) begin
            if (cnt >= 3 && cnt < 11) a = {a[6:0], srom_di};
            cnt = cnt + 1;
        end
    end
    // data leaves msb first on falling edges once the address is in
    always @(negedge srom_sk) begin
        if (srom_cs && cnt == 11) sh = mem[a[4:0]];
        if (srom_cs && cnt >= 11) begin
            srom_do = sh[15];
            sh = sh << 1;
        end
    end
    // a deselected part must not look like it still holds its last bit
    always @(negedge srom_cs or posedge clr) begin
        if (clr) begin
            rd_cnt = 0;
            ord_err = 1'b0;
        end else begin
            if (cnt == 27) begin
                if (a !== rd_cnt[7:0]) ord_err = 1'b1;
                rd_cnt = rd_cnt + 1;
            end
            cnt = 0;
            srom_do = ~srom_do;
        end
    end
endmodule

// >>> eeprom_config_loader_test.sv
// self-checking bench for the configuration loader with an eeprom model
// assumes the management line has a pull-up; bench drives on falling edges
`timescale 1ns/100ps
module eeprom_config_loader_test
    import ecl_pkg::*;
();
    logic ref_clk = 1'b0, rst_n = 1'b0, clr = 1'b0, full_duplex = 1'b0;
    logic usb_bus_reset = 1'b0, phy_reset_level = 1'b0, phy_reset_enable = 1'b0;
    logic [7:0] rx_free_cnt = 8'h00;
    logic srom_cs, srom_sk, srom_di, srom_do, mdc, mdio_o, mdio_oe_n, ord_err;
    logic phy_reset_out_n, pause_req, cfg_valid, usb_enum_en, mgmt_grant;
    logic primary_is_internal, mdio_in_seen;
    logic [15:0] rx_free_bytes, max_frame_size;
    logic [47:0] station_addr;
    logic [4:0] int_ep_reg1, int_ep_reg2;
    logic [7:0] pause_high_mark, pause_low_mark;
    ecl_flags_s flags;
    ecl_phy_s primary_phy, secondary_phy;
    logic [63:0] sh64;
    logic [63:0] frames [$];
    int rd_cnt, bad_count = 0, checked = 0;
    wire mdio_w = mdio_oe_n ? 1'b1 : mdio_o;
    always #5 ref_clk = ~ref_clk;
    // short link half periods keep the run brief
    ecl_loader #(.SROM_HALF(4), .MDC_HALF(4)) u_dut (.ref_clk, .rst_n, .srom_cs,
        .srom_sk, .srom_di, .srom_do, .mdc, .mdio_i(mdio_w), .mdio_o, .mdio_oe_n,
        .usb_bus_reset, .phy_reset_level, .phy_reset_enable, .phy_reset_out_n,
        .full_duplex, .rx_free_cnt, .rx_free_bytes, .pause_req, .cfg_valid,
        .usb_enum_en, .mgmt_grant, .flags, .station_addr, .int_ep_reg1, .int_ep_reg2,
        .max_frame_size, .primary_phy, .secondary_phy, .primary_is_internal,
        .pause_high_mark, .pause_low_mark, .mdio_in_seen);
    ecl_srom_model u_rom (.srom_cs, .srom_sk, .srom_di, .clr, .srom_do, .rd_cnt, .ord_err);
    // capture each management frame msb first while the block drives the line
    always @(posedge mdc) if (!mdio_oe_n) sh64 <= {sh64[62:0], mdio_o};
    always @(posedge mdio_oe_n) frames.push_back(sh64);
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (bad_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // bounded wait; a miss shows up in the checks that follow
    task automatic wait_lvl(input bit fin);
        for (int n = 0; n < 20000 && (fin ? cfg_valid : !mdio_oe_n) !== 1'b1; n++) settle(1);
    endtask
    // image 0 sets reserved flag bits, image 1 only the debug port bit
    task automatic t_load(input bit b);
        for (int i = 0; i < 32; i++) u_rom.mem[i] = 16'hA500 + 16'(i);
        u_rom.mem[0] = 16'h0003; // count word is not trusted
        u_rom.mem[1] = b ? 16'h0200 : 16'hFDF7;
        u_rom.mem[4] = b ? 16'hDCFE : 16'h2301;
        u_rom.mem[5] = b ? 16'h98BA : 16'h6745;
        u_rom.mem[6] = b ? 16'h5476 : 16'hAB89;
        u_rom.mem[15] = b ? 16'h0215 : 16'hFFEA;
        u_rom.mem[16] = b ? 16'h05EE : 16'h09C4;
        u_rom.mem[17] = b ? 16'h1F01 : 16'hE310;
        u_rom.mem[18] = b ? 16'h0810 : 16'h2040;
        rst_n = 1'b0;
        clr = 1'b1;
        settle(4);
        // the enable leaves unknown with a rising edge as reset first resolves
        frames.delete();
        clr = 1'b0;
        rst_n = 1'b1;
        wait_lvl(1'b0);
        chk(rd_cnt, 21);
        chk(ord_err, 0);
        chk({cfg_valid, usb_enum_en}, 0);
        wait_lvl(1'b1);
        settle(2);
        chk(frames.size(), 3);
    endtask
    task automatic t_frames;
        logic [4:0] ids [3];
        ids = '{5'h00, u_rom.mem[17][4:0], u_rom.mem[17][12:8]};
        for (int i = 0; i < 3; i++)
            chk(frames[i], {32'hFFFF_FFFF, 4'h5, ids[i], 5'h00, 2'b10, PHY_POWER_DOWN});
    endtask
    task automatic t_decode;
        logic [15:0] m [0:31];
        m = u_rom.mem;
        chk(flags, {m[1][0], m[1][2], m[1][4], m[1][5], m[1][6], m[1][7], m[1][8], m[1][9]});
        chk(station_addr, {m[4][7:0], m[4][15:8], m[5][7:0], m[5][15:8], m[6][7:0], m[6][15:8]});
        chk({int_ep_reg1, int_ep_reg2}, {m[15][12:8], m[15][4:0]});
        chk(max_frame_size, m[16]);
        chk(primary_phy, {m[17][7:0], m[17][7:5] == 3'b000});
        chk(secondary_phy, {m[17][15:8], m[17][15:13] == 3'b000});
        chk(primary_is_internal, m[17][4:0] == 5'b1_0000);
        chk({pause_high_mark, pause_low_mark}, m[18]);
        chk({usb_enum_en, mgmt_grant, mdio_in_seen}, 3'b111);
    endtask
    task automatic t_phy_reset;
        for (int i = 0; i < 8; i++) begin
            {usb_bus_reset, phy_reset_level, phy_reset_enable} = 3'(i);
            settle(1);
            chk(phy_reset_out_n, u_rom.mem[1][5] ? !(phy_reset_enable && !phy_reset_level)
                : !(phy_reset_enable && usb_bus_reset));
        end
    endtask
    task automatic p_step(input logic [7:0] c, input logic fd, input logic exp);
        rx_free_cnt = c;
        full_duplex = fd;
        settle(2);
        chk(pause_req, exp);
        chk(rx_free_bytes, {c, 8'h00});
    endtask
    // just above high, at high, just below low, at low, then half duplex
    task automatic t_pause;
        p_step(u_rom.mem[18][15:8] + 8'h01, 1'b1, 1'b0);
        p_step(u_rom.mem[18][15:8], 1'b1, 1'b1);
        p_step(u_rom.mem[18][7:0] - 8'h01, 1'b1, 1'b1);
        p_step(u_rom.mem[18][7:0], 1'b1, 1'b0);
        p_step(u_rom.mem[18][15:8], 1'b0, 1'b0);
    endtask
    // reset in mid-preload must drop the link and the valid flag at once
    task automatic t_abort;
        rst_n = 1'b0;
        settle(4);
        rst_n = 1'b1;
        settle(300);
        rst_n = 1'b0;
        settle(2);
        chk({cfg_valid, srom_cs, mdio_oe_n}, 3'b001);
    endtask
    task automatic t_run(input bit b);
        t_load(b);
        t_frames;
        t_decode;
        t_phy_reset;
        t_pause;
    endtask
    initial begin
        t_run(1'b0);
        t_abort;
        t_run(1'b1);
        tally_and_finish;
    end
    // two full loads take well under a fifth of this span
    initial begin
        #1_000_000;
        bad_count++;
        tally_and_finish;
    end
endmodule
